/* File: bench/mgmt_station_model.sv */
// station manager model: standard management frames on mdc and mdio
// assumes mclk paces it; the mdio line has a pull-up when nobody drives it
`timescale 1ns/1ps
`default_nettype none
module mgmt_station_model (
   input wire logic mclk,
   input wire logic mdio_out,
   input wire logic mdio_oe_n,
   output logic mdc,
   output logic mdio_in
);
   logic drv_q;
   logic bit_q;

   // wire level: device first, then manager, else the pull-up
   assign mdio_in = !mdio_oe_n ? mdio_out : (drv_q ? bit_q : 1'b1);

   // mdc stands low between frames, it never runs free
   initial begin
      mdc = 1'b0;
      drv_q = 1'b0;
      bit_q = 1'b1;
   end

   // one mdc period of 17 mclk; sample just before the rise, since the device
   // moves its read bit a few mclk after each rise
   task automatic one_bit(input logic b, input logic drive, output logic seen);
      @(posedge mclk);
      mdc <= 1'b0;
      bit_q <= b;
      drv_q <= drive;
      repeat (8) @(posedge mclk);
      seen = mdio_in;
      mdc <= 1'b1;
      repeat (8) @(posedge mclk);
   endtask

   // whole frame: 32 preamble ones, start, op, phy, reg, turnaround, 16 data
   task automatic frame(input logic rd, input logic [4:0] phy, input logic [4:0] reg_a,
                        input logic [15:0] wd, output logic [15:0] rd_data);
      logic [45:0] hdr;
      logic s;
      int i;
      rd_data = 16'h0000;
      hdr = {32'hFFFF_FFFF, 2'b01, (rd ? 2'b10 : 2'b01), phy, reg_a};
      for (i = 45; i >= 0; i--) one_bit(hdr[i], 1'b1, s);
      if (rd) begin
         // line released for turnaround and data
         for (i = 17; i >= 0; i--) begin
            one_bit(1'b1, 1'b0, s);
            if (i < 16) rd_data[i] = s;
         end
      end else begin
         one_bit(1'b1, 1'b1, s);
         one_bit(1'b0, 1'b1, s);
         for (i = 15; i >= 0; i--) one_bit(wd[i], 1'b1, s);
      end
      one_bit(1'b1, 1'b0, s);
      @(posedge mclk);
      mdc <= 1'b0;
   endtask
endmodule // mgmt_station_model
`default_nettype wire

/* File: bench/tb_phy_management_register_bank.sv */
// self-checking bench of the management register bank, all access over mdc/mdio
// assumes mgmt_station_model and the constants header phy_mgmt_map.svh
`include "phy_mgmt_map.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_phy_management_register_bank;
   localparam logic [15:0] ID_H = 16'hA0B1; // arbitrary value
   localparam logic [15:0] ID_L = 16'hC2D3; // arbitrary value
   logic mclk, rst, mdc, mdio_in, mdio_out, mdio_oe_n, tx_en, fibre_mode;
   logic strap_lb, strap_ne, strap_m0, strap_m1, neg_spd, neg_fd;
   logic loopback_on, speed_100, full_duplex, negotiation_on, negotiation_restart;
   logic power_down, isolate, mac_oe_n, collision, soft_reset_busy;
   logic [4:0] addr_strap;
   logic [4:0] phy;
   logic [15:0] rdata;
   logic [4:0] offs [21];
   logic [15:0] vals [21];
   logic [15:0] partner_ab, partner_np;
   int mismatches, n_checks, i;
   int n_pulse = 0;

   // soft reset shortened so a poll by frames still catches it busy
   phy_management_register_bank #(.SOFT_RESET_CYCLES(2500), .ID_HIGH(ID_H), .ID_LOW(ID_L)) dut (
      .mclk(mclk), .rst(rst), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
      .mdio_oe_n(mdio_oe_n), .loopback_strap(strap_lb), .negotiation_enable_strap(strap_ne),
      .mode_0_strap(strap_m0), .mode_1_strap(strap_m1), .phy_address_strap(addr_strap),
      .fibre_mode(fibre_mode), .tx_en(tx_en), .neg_speed_100(neg_spd),
      .neg_full_duplex(neg_fd), .partner_ability_in(partner_ab),
      .partner_next_page_in(partner_np), .loopback_on(loopback_on), .speed_100(speed_100),
      .full_duplex(full_duplex), .negotiation_on(negotiation_on),
      .negotiation_restart(negotiation_restart), .power_down(power_down),
      .isolate(isolate), .mac_oe_n(mac_oe_n), .collision(collision),
      .soft_reset_busy(soft_reset_busy));

   mgmt_station_model sm (.mclk(mclk), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
      .mdc(mdc), .mdio_in(mdio_in));

   // 250 MHz device clock
   initial mclk = 1'b0;
   always #2 mclk = ~mclk;

   // restart is a one-cycle pulse, so count rather than sample it
   always @(posedge mclk) if (negotiation_restart === 1'b1) n_pulse++;

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      n_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic rd(input logic [4:0] a, input logic [15:0] want);
      sm.frame(1'b1, phy, a, 16'h0000, rdata);
      check(rdata, want);
   endtask

   // mode outputs lag the register by a couple of cycles
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      sm.frame(1'b0, phy, a, d, rdata);
      repeat (6) @(posedge mclk);
   endtask

   task automatic hw_reset(input logic [4:0] a);
      @(posedge mclk);
      rst <= 1'b1;
      addr_strap <= a;
      phy <= a;
      repeat (3) @(posedge mclk);
      rst <= 1'b0;
      repeat (12) @(posedge mclk);
   endtask

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // main sequence
   initial begin
      rst = 1'b1;
      tx_en = 1'b0;
      fibre_mode = 1'b0;
      {strap_lb, strap_ne, strap_m0, strap_m1, neg_spd, neg_fd} = 6'b011000;
      addr_strap = 5'h01;
      phy = 5'h01;
      mismatches = 0;
      n_checks = 0;
      partner_ab = 16'h0000;
      partner_np = 16'h0000;
      offs = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h10, 5'h11,
               5'h12, 5'h13, 5'h14, 5'h18, 5'h19, 5'h1B, 5'h1C, 5'h1E, 5'h1F, 5'h0A};
      vals = '{16'h3000, 16'h7849, ID_H, ID_L, 16'h05E1, 16'h0000, 16'h0004, 16'h2001,
               16'h0000, 16'h1200, 16'h0000, 16'h0100, 16'h0140, 16'h000A, 16'h0027,
               16'h0000, 16'h000A, 16'h0820, 16'h0000, 16'h0000, 16'h0000};
      hw_reset(5'h01);
      check(isolate, 1'b0);
      check(negotiation_on, 1'b1);
      for (i = 0; i < 21; i++) rd(offs[i], vals[i]);
      // partner pages arrive from negotiation logic and show up at once
      partner_ab <= 16'h45E1;
      partner_np <= 16'h2801;
      rd(`REG_PARTNER, 16'h45E1);
      rd(`REG_PARTNER_NP, 16'h2801);
      wr(`REG_ADV, 16'h1234);
      rd(`REG_ADV, 16'h1234);
      wr(5'h0A, 16'hFFFF);
      rd(5'h0A, 16'h0000);
      // forced speed and duplex, then masked by negotiation
      wr(`REG_CTRL, 16'h2100);
      check({speed_100, full_duplex, negotiation_on}, 3'b110);
      wr(`REG_CTRL, 16'h3100);
      check({speed_100, full_duplex}, 2'b00);
      rd(`REG_CTRL, 16'h3100);
      i = n_pulse;
      wr(`REG_CTRL, 16'h1200);
      rd(`REG_CTRL, 16'h1000);
      // negotiation off first, so the restart below finds it disabled
      wr(`REG_CTRL, 16'h0000);
      wr(`REG_CTRL, 16'h0200);
      check(16'(n_pulse - i), 16'h0001);
      // collision test only counts inside loop-back
      wr(`REG_CTRL, 16'h4080);
      tx_en <= 1'b1;
      repeat (8) @(posedge mclk);
      check({loopback_on, collision}, 2'b11);
      tx_en <= 1'b0;
      repeat (8) @(posedge mclk);
      check(collision, 1'b0);
      wr(`REG_CTRL, 16'h0080);
      tx_en <= 1'b1;
      repeat (8) @(posedge mclk);
      check(collision, 1'b0);
      tx_en <= 1'b0;
      wr(`REG_CTRL, 16'h0C7F);
      check({isolate, mac_oe_n, power_down}, 3'b111);
      rd(`REG_CTRL, 16'h0C00);
      fibre_mode <= 1'b1;
      wr(`REG_CTRL, 16'h1000);
      check(negotiation_on, 1'b0);
      fibre_mode <= 1'b0;
      wr(`REG_SHADOW_EN, 16'h0080);
      rd(`REG_AUX_MODE2, 16'h0000);
      wr(`REG_AUX_MODE2, 16'h5A5A);
      rd(`REG_AUX_MODE2, 16'h5A5A);
      wr(`REG_SHADOW_EN, 16'h0000);
      rd(`REG_AUX_MODE2, 16'h000A);
      // straps moved first, so a resample by soft reset would show
      strap_ne <= 1'b0;
      strap_m0 <= 1'b0;
      wr(`REG_CTRL, 16'h8000);
      check(soft_reset_busy, 1'b1);
      wr(`REG_CTRL, 16'h0800);
      sm.frame(1'b1, phy, `REG_CTRL, 16'h0000, rdata);
      check(16'(rdata[15]), 16'h0001);
      i = 0;
      while (rdata[15] !== 1'b0 && i < 8) begin
         sm.frame(1'b1, phy, `REG_CTRL, 16'h0000, rdata);
         i++;
      end
      if (rdata[15] !== 1'b0) begin
         mismatches++;
         tally_and_finish();
      end
      rd(`REG_CTRL, 16'h3000);
      // fresh hardware reset with all-zero address and negotiation strapped off
      hw_reset(5'h00);
      check({isolate, mac_oe_n}, 2'b11);
      rd(`REG_CTRL, 16'h0400);
      wr(`REG_CTRL, 16'h1000);
      rd(`REG_CTRL, 16'h0000);
      tally_and_finish();
   end
endmodule // tb_phy_management_register_bank
`default_nettype wire

/* File: rtl/phy_management_register_bank.sv */
// management register bank with its serial management slave and the control outputs
// assumes MDC and MDIO, straps and transmit enable are asynchronous pins; negotiation
// results and partner pages come from logic on mclk
`include "phy_mgmt_map.svh"
`timescale 1ns/1ps
`default_nettype none

module phy_management_register_bank #(
   parameter int unsigned SOFT_RESET_CYCLES = `SOFT_RESET_NS / `MCLK_PERIOD_NS,
   parameter logic [15:0] ID_HIGH = 16'h1234, // arbitrary value
   parameter logic [15:0] ID_LOW = 16'h5678 // arbitrary value
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic mdc,
   input wire logic mdio_in,
   output logic mdio_out,
   output logic mdio_oe_n,
   input wire logic loopback_strap,
   input wire logic negotiation_enable_strap,
   input wire logic mode_0_strap,
   input wire logic mode_1_strap,
   input wire logic [4:0] phy_address_strap,
   input wire logic fibre_mode,
   input wire logic tx_en,
   input wire logic neg_speed_100,
   input wire logic neg_full_duplex,
   input wire logic [15:0] partner_ability_in,
   input wire logic [15:0] partner_next_page_in,
   output logic loopback_on,
   output logic speed_100,
   output logic full_duplex,
   output logic negotiation_on,
   output logic negotiation_restart,
   output logic power_down,
   output logic isolate,
   output logic mac_oe_n,
   output logic collision,
   output logic soft_reset_busy
);

   localparam logic [17:0] SRST_LAST = 18'(SOFT_RESET_CYCLES - 1);

   // synchronisers: first stage read only by the second
   logic [2:0] mdc_s;
   logic [1:0] mdio_s, tx_en_s, fibre_s;
   logic [8:0] strap_s1, strap_s2;
   always_ff @(posedge mclk) begin
      mdc_s <= {mdc_s[1:0], mdc};
      mdio_s <= {mdio_s[0], mdio_in};
      tx_en_s <= {tx_en_s[0], tx_en};
      fibre_s <= {fibre_s[0], fibre_mode};
      // straps only need to settle, not align: they are taken well after reset
      strap_s1 <= {loopback_strap, negotiation_enable_strap, mode_0_strap,
                   mode_1_strap, phy_address_strap};
      strap_s2 <= strap_s1;
   end

   logic mdc_rise;
   assign mdc_rise = mdc_s[1] & ~mdc_s[2];

   // strap capture: waits for the synchronisers to settle after hardware reset
   phy_mgmt_pkg::strap_t strap_q;
   logic [1:0] strap_cnt_q;
   logic strap_done_q;
   logic strap_take;
   assign strap_take = !strap_done_q && strap_cnt_q == `STRAP_SETTLE;
   always_ff @(posedge mclk) begin
      if (rst) begin
         strap_cnt_q <= 2'h0;
         strap_done_q <= 1'b0;
         strap_q <= '0;
      end else if (strap_take) begin
         strap_done_q <= 1'b1;
         strap_q <= strap_s2[8:0]; // soft reset never comes here
      end else if (!strap_done_q) begin
         strap_cnt_q <= strap_cnt_q + 2'h1;
      end
   end

   // control defaults built from straps
   function automatic phy_mgmt_pkg::ctrl_t strap_ctrl(input phy_mgmt_pkg::strap_t s);
      phy_mgmt_pkg::ctrl_t c;
      c = '0;
      c.loopback = s.loopback;
      c.neg_enable = s.neg_enable;
      c.speed_100 = s.mode_0;
      c.full_duplex = s.mode_1;
      c.isolate = (s.phy_address == 5'h00);
      return c;
   endfunction

   // writable register reset values
   function automatic logic [15:0] reset_value(input logic [4:0] a);
      unique case (a)
         `REG_ADV: reset_value = `RST_ADV;
         `REG_NP_TX: reset_value = `RST_NP_TX;
         `REG_RMII_TEST: reset_value = `RST_RMII_TEST;
         `REG_FAST_TX: reset_value = `RST_FAST_TX;
         `REG_RX_MODE: reset_value = `RST_RX_MODE;
         `REG_AUX_CTRL: reset_value = `RST_AUX_CTRL;
         `REG_AUX_MODE2: reset_value = `RST_AUX_MODE2;
         `REG_AUX_PHY: reset_value = `RST_AUX_PHY;
         `REG_SHADOW_EN: reset_value = `RST_SHADOW_EN;
         default: reset_value = `RST_ZERO;
      endcase
   endfunction

   function automatic logic is_writable(input logic [4:0] a);
      is_writable = (a == `REG_ADV) || (a == `REG_NP_TX) || (a == `REG_RMII_TEST) ||
                    (a == `REG_FAST_TX) || (a == `REG_RX_MODE) || (a == `REG_AUX_CTRL) ||
                    (a == `REG_AUX_MODE2) || (a == `REG_AUX_PHY) || (a == `REG_SHADOW_EN);
   endfunction

   phy_mgmt_pkg::ctrl_t ctrl_q;
   logic [15:0] regs_q [0:31];
   logic [15:0] shadow_q;
   logic [17:0] srst_cnt_q;
   logic srst_done;
   phy_mgmt_pkg::mgmt_write_t wr_q;
   phy_mgmt_pkg::ctrl_t wr_ctrl;
   logic neg_eff;
   logic shadow_sel;

   assign wr_ctrl = phy_mgmt_pkg::ctrl_t'(wr_q.data);
   assign srst_done = ctrl_q.soft_reset && srst_cnt_q == SRST_LAST;
   // fibre or a strap-off negotiation leaves it disabled
   assign neg_eff = ctrl_q.neg_enable & strap_q.neg_enable & ~fibre_s[1];
   assign shadow_sel = regs_q[`REG_SHADOW_EN][`SHADOW_SEL_BIT];

   // basic control register
   always_ff @(posedge mclk) begin
      if (rst) begin
         ctrl_q <= '0;
      end else if (strap_take) begin
         ctrl_q <= strap_ctrl(strap_s2[8:0]);
      end else if (srst_done) begin
         ctrl_q <= strap_ctrl(strap_q); // self-clear, defaults from latched straps
      end else if (wr_q.valid && wr_q.addr == `REG_CTRL && !ctrl_q.soft_reset) begin
         // writes while soft reset runs are dropped
         ctrl_q.soft_reset <= wr_ctrl.soft_reset;
         ctrl_q.loopback <= wr_ctrl.loopback;
         ctrl_q.speed_100 <= wr_ctrl.speed_100;
         ctrl_q.full_duplex <= wr_ctrl.full_duplex;
         if (strap_q.neg_enable) begin
            ctrl_q.neg_enable <= wr_ctrl.neg_enable;
         end
         ctrl_q.power_down <= wr_ctrl.power_down;
         ctrl_q.isolate <= wr_ctrl.isolate;
         ctrl_q.collision_test <= wr_ctrl.collision_test;
      end
   end

   // soft reset duration counter
   // only its end matters; 18 bits cover 1 ms of mclk
   always_ff @(posedge mclk) begin
      if (rst || !ctrl_q.soft_reset) begin
         srst_cnt_q <= 18'h0_0000;
      end else begin
         srst_cnt_q <= srst_cnt_q + 18'h0_0001;
      end
   end

   // ordinary read/write registers and the shadow behind 1Bh
   always_ff @(posedge mclk) begin
      if (rst || srst_done) begin
         for (int i = 0; i < 32; i++) begin
            regs_q[i] <= reset_value(5'(i));
         end
         shadow_q <= `RST_SHADOW;
      // the select bit lives at 1Fh, so 1Bh writes reach the shadow only after setting it
      end else if (wr_q.valid && wr_q.addr == `REG_AUX_MODE2 && shadow_sel) begin
         shadow_q <= wr_q.data;
      end else if (wr_q.valid && is_writable(wr_q.addr)) begin
         regs_q[wr_q.addr] <= wr_q.data; // unmapped offsets fall through
      end
   end

   // read multiplexer
   function automatic logic [15:0] read_reg(input logic [4:0] a);
      unique case (a)
         // mask drops only the self-clearing restart bit, duplex stays visible
         `REG_CTRL: read_reg = {ctrl_q[15:7] & 9'h1FB, 7'h00}; // restart reads 0
         `REG_STATUS: read_reg = `RST_STATUS;
         `REG_ID_HIGH: read_reg = ID_HIGH;
         `REG_ID_LOW: read_reg = ID_LOW;
         `REG_PARTNER: read_reg = partner_ability_in;
         `REG_EXPANSION: read_reg = `RST_EXPANSION;
         `REG_PARTNER_NP: read_reg = partner_next_page_in;
         `REG_RX_CFG_IRQ: read_reg = `RST_RX_CFG_IRQ;
         `REG_RX_EVT_IRQ: read_reg = `RST_RX_EVT_IRQ;
         `REG_AUX_STATUS: read_reg = `RST_AUX_STATUS;
         `REG_SLOW_STATUS: read_reg = `RST_SLOW_STATUS;
         `REG_AUX_MODE2: read_reg = shadow_sel ? shadow_q : regs_q[a];
         default: read_reg = is_writable(a) ? regs_q[a] : `RST_ZERO;
      endcase
   endfunction

   // management frame slave, acting on rising MDC; read data moves after each rise
   phy_mgmt_pkg::mdio_state_t st_q;
   logic [5:0] pre_cnt_q;
   logic [3:0] bit_cnt_q;
   logic [15:0] shift_q;
   logic [11:0] hdr_q;
   logic [11:0] hdr_d;
   assign hdr_d = {hdr_q[10:0], mdio_s[1]};

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= phy_mgmt_pkg::MDIO_PREAMBLE;
         pre_cnt_q <= 6'h00;
         bit_cnt_q <= 4'h0;
         shift_q <= 16'h0000;
         hdr_q <= 12'h000;
         wr_q <= '0;
         mdio_out <= 1'b1;
         mdio_oe_n <= 1'b1;
      end else begin
         wr_q.valid <= 1'b0;
         if (mdc_rise) begin
            unique case (st_q)
               phy_mgmt_pkg::MDIO_PREAMBLE: begin
                  mdio_oe_n <= 1'b1;
                  if (mdio_s[1]) begin
                     if (pre_cnt_q != `MDIO_PREAMBLE_BITS) begin
                        pre_cnt_q <= pre_cnt_q + 6'h01;
                     end
                  end else begin
                     if (pre_cnt_q == `MDIO_PREAMBLE_BITS) begin
                        st_q <= phy_mgmt_pkg::MDIO_START;
                     end
                     pre_cnt_q <= 6'h00;
                  end
               end
               phy_mgmt_pkg::MDIO_START: begin
                  bit_cnt_q <= 4'h0;
                  st_q <= mdio_s[1] ? phy_mgmt_pkg::MDIO_HEADER : phy_mgmt_pkg::MDIO_PREAMBLE;
               end
               phy_mgmt_pkg::MDIO_HEADER: begin
                  hdr_q <= hdr_d;
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == `MDIO_HDR_LAST) begin
                     bit_cnt_q <= 4'h0;
                     // other addresses and malformed codes fall back to preamble hunting
                     if (strap_done_q && hdr_d[9:5] == strap_q.phy_address &&
                         hdr_d[11:10] == `MDIO_OP_READ) begin
                        st_q <= phy_mgmt_pkg::MDIO_TURN_READ;
                        shift_q <= read_reg(hdr_d[4:0]);
                     end else if (strap_done_q && hdr_d[9:5] == strap_q.phy_address &&
                                  hdr_d[11:10] == `MDIO_OP_WRITE) begin
                        st_q <= phy_mgmt_pkg::MDIO_TURN_WRITE;
                     end else begin
                        st_q <= phy_mgmt_pkg::MDIO_PREAMBLE;
                     end
                  end
               end
               phy_mgmt_pkg::MDIO_TURN_READ: begin
                  mdio_oe_n <= 1'b0; // second turnaround bit driven low
                  mdio_out <= 1'b0;
                  st_q <= phy_mgmt_pkg::MDIO_READ_DATA;
               end
               phy_mgmt_pkg::MDIO_READ_DATA: begin
                  mdio_out <= shift_q[15];
                  shift_q <= {shift_q[14:0], 1'b0};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == `MDIO_DATA_LAST) begin
                     st_q <= phy_mgmt_pkg::MDIO_PREAMBLE; // release on next rise
                  end
               end
               phy_mgmt_pkg::MDIO_TURN_WRITE: begin
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q[0]) begin
                     bit_cnt_q <= 4'h0;
                     st_q <= phy_mgmt_pkg::MDIO_WRITE_DATA;
                  end
               end
               phy_mgmt_pkg::MDIO_WRITE_DATA: begin
                  shift_q <= {shift_q[14:0], mdio_s[1]};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q == `MDIO_DATA_LAST) begin
                     wr_q.valid <= 1'b1;
                     wr_q.addr <= hdr_q[4:0];
                     wr_q.data <= {shift_q[14:0], mdio_s[1]};
                     st_q <= phy_mgmt_pkg::MDIO_PREAMBLE;
                  end
               end
            endcase
         end
      end
   end

   // operating mode outputs, all registered
   always_ff @(posedge mclk) begin
      if (rst) begin
         loopback_on <= 1'b0;
         speed_100 <= 1'b0;
         full_duplex <= 1'b0;
         negotiation_on <= 1'b0;
         power_down <= 1'b0;
         isolate <= 1'b0;
         mac_oe_n <= 1'b1;
         soft_reset_busy <= 1'b0;
      end else begin
         loopback_on <= ctrl_q.loopback;
         // negotiated results win while negotiation runs
         speed_100 <= neg_eff ? neg_speed_100 : ctrl_q.speed_100;
         full_duplex <= neg_eff ? neg_full_duplex : ctrl_q.full_duplex;
         negotiation_on <= neg_eff;
         power_down <= ctrl_q.power_down;
         isolate <= ctrl_q.isolate;
         mac_oe_n <= ctrl_q.isolate; // MAC-side outputs float while isolated
         soft_reset_busy <= ctrl_q.soft_reset;
      end
   end

   // restart pulse, dropped when negotiation is off
   // gated on the enable standing before the write, not the value being written
   always_ff @(posedge mclk) begin
      if (rst) begin
         negotiation_restart <= 1'b0;
      end else begin
         negotiation_restart <= wr_q.valid && wr_q.addr == `REG_CTRL && wr_ctrl.neg_restart &&
                                !ctrl_q.soft_reset && neg_eff;
      end
   end

   // collision test: a few mclk cycles, far inside 4 bit times at 100 Mb/s
   // registered, so the pin trails the tx_en pin by about three mclk
   always_ff @(posedge mclk) begin
      if (rst) begin
         collision <= 1'b0;
      end else begin
         collision <= ctrl_q.collision_test & ctrl_q.loopback & tx_en_s[1];
      end
   end

   // checks, all on mclk; rst is synchronous, so disable iff covers it
   // mac_oe_n resets high while isolate resets low: skip the edge right after reset
   isolate_gates_mac_a: assert property (@(posedge mclk) disable iff (rst)
      !$past(rst) |-> mac_oe_n == $past(ctrl_q.isolate))
      else $error("MAC enable does not follow isolate");
   collision_needs_loop_a: assert property (@(posedge mclk) disable iff (rst)
      collision |-> $past(ctrl_q.loopback) && $past(ctrl_q.collision_test))
      else $error("collision raised outside loop-back test");
   collision_timing_a: assert property (@(posedge mclk) disable iff (rst)
      (ctrl_q.collision_test && ctrl_q.loopback && tx_en_s[1])[*2] |-> collision)
      else $error("collision late after transmit enable");
   restart_gated_a: assert property (@(posedge mclk) disable iff (rst)
      negotiation_restart |-> $past(neg_eff))
      else $error("restart while negotiation disabled");
   fibre_no_neg_a: assert property (@(posedge mclk) disable iff (rst)
      fibre_s[1] |=> !negotiation_on)
      else $error("negotiation on in fibre mode");
   forced_speed_a: assert property (@(posedge mclk) disable iff (rst)
      !neg_eff |=> speed_100 == $past(ctrl_q.speed_100))
      else $error("forced speed not applied");
   forced_duplex_a: assert property (@(posedge mclk) disable iff (rst)
      neg_eff |=> full_duplex == $past(neg_full_duplex))
      else $error("forced duplex leaked while negotiating");
   srst_blocks_write_a: assert property (@(posedge mclk) disable iff (rst)
      ctrl_q.soft_reset && !srst_done |=> $stable(ctrl_q[14:7]))
      else $error("control changed during soft reset");
   srst_end_a: assert property (@(posedge mclk) disable iff (rst)
      srst_done |=> !ctrl_q.soft_reset && ctrl_q == strap_ctrl(strap_q))
      else $error("soft reset did not restore strap defaults");
   unmapped_zero_a: assert property (@(posedge mclk) disable iff (rst)
      read_reg(5'h0A) == `RST_ZERO)
      else $error("unmapped offset reads nonzero");

endmodule // phy_management_register_bank

`default_nettype wire

/* File: rtl/phy_mgmt_map.svh */
// constants of the transceiver management register bank: offsets, reset values, timing
// assumes the management link runs from one device clock of 250 MHz
`ifndef PHY_MGMT_MAP_SVH
`define PHY_MGMT_MAP_SVH

`define REG_CTRL 5'h00
`define REG_STATUS 5'h01
`define REG_ID_HIGH 5'h02
`define REG_ID_LOW 5'h03
`define REG_ADV 5'h04
`define REG_PARTNER 5'h05
`define REG_EXPANSION 5'h06
`define REG_NP_TX 5'h07
`define REG_PARTNER_NP 5'h08
`define REG_RMII_TEST 5'h10
`define REG_RX_CFG_IRQ 5'h11
`define REG_RX_EVT_IRQ 5'h12
`define REG_FAST_TX 5'h13
`define REG_RX_MODE 5'h14
`define REG_AUX_CTRL 5'h18
`define REG_AUX_STATUS 5'h19
`define REG_AUX_MODE2 5'h1B
`define REG_SLOW_STATUS 5'h1C
`define REG_AUX_PHY 5'h1E
`define REG_SHADOW_EN 5'h1F

`define RST_STATUS 16'h7849
`define RST_ADV 16'h05E1
`define RST_PARTNER 16'h0000
`define RST_EXPANSION 16'h0004
`define RST_NP_TX 16'h2001
`define RST_RMII_TEST 16'h1200
`define RST_RX_CFG_IRQ 16'h0000
`define RST_RX_EVT_IRQ 16'h0100
`define RST_FAST_TX 16'h0140
`define RST_RX_MODE 16'h000A
`define RST_AUX_CTRL 16'h0027
`define RST_AUX_STATUS 16'h0000
`define RST_AUX_MODE2 16'h000A
`define RST_SHADOW 16'h0000
`define RST_SLOW_STATUS 16'h0820
`define RST_AUX_PHY 16'h0000
`define RST_SHADOW_EN 16'h0000
`define RST_ZERO 16'h0000

// shadow select bit inside the enable register
`define SHADOW_SEL_BIT 7

// management frame fields
`define MDIO_PREAMBLE_BITS 6'h20
`define MDIO_HDR_LAST 4'hB
`define MDIO_DATA_LAST 4'hF
`define MDIO_OP_READ 2'h2
`define MDIO_OP_WRITE 2'h1

// timing
`define MCLK_PERIOD_NS 4
`define SOFT_RESET_NS 1000000
`define STRAP_SETTLE 2'h3

`endif

/* File: rtl/phy_mgmt_pkg.sv */
// types of the transceiver management register bank
// assumes the constants header is included by the files that need offsets
package phy_mgmt_pkg;

   // basic control register layout, bit 15 first
   typedef struct packed {
      logic soft_reset;
      logic loopback;
      logic speed_100;
      logic neg_enable;
      logic power_down;
      logic isolate;
      logic neg_restart;
      logic full_duplex;
      logic collision_test;
      logic [6:0] reserved;
   } ctrl_t;

   // levels caught from the strap pins after hardware reset
   typedef struct packed {
      logic loopback;
      logic neg_enable;
      logic mode_0;
      logic mode_1;
      logic [4:0] phy_address;
   } strap_t;

   // one decoded management write
   typedef struct packed {
      logic valid;
      logic [4:0] addr;
      logic [15:0] data;
   } mgmt_write_t;

   typedef enum logic [2:0] {
      MDIO_PREAMBLE,
      MDIO_START,
      MDIO_HEADER,
      MDIO_TURN_READ,
      MDIO_TURN_WRITE,
      MDIO_READ_DATA,
      MDIO_WRITE_DATA
   } mdio_state_t;

endpackage
